// *** lpsm_pkg.sv ***
// Constants and types shared by the link power status manager files
package lpsm_pkg;

	// Timing: figures as printed, cycle counts derived from the 25 MHz clock
	localparam int CLK_PERIOD_NS      = 40;
	localparam int IFACE_RESET_TO_NS  = 2600;
	localparam int IFACE_DIS_TO_NS    = 26000;
	localparam int PWRUP_LKON_NS      = 167000;
	localparam int IFACE_RESET_TO_CYC = (IFACE_RESET_TO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IFACE_DIS_TO_CYC   = (IFACE_DIS_TO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWRUP_LKON_CYC     = PWRUP_LKON_NS / CLK_PERIOD_NS;
	localparam int LKON_PERIOD_CYC    = 8;

	localparam logic [9:0]  IFR_CNT     = 10'(IFACE_RESET_TO_CYC);
	localparam logic [9:0]  IFD_CNT     = 10'(IFACE_DIS_TO_CYC);
	localparam logic [9:0]  LPS_CNT_SAT = 10'(IFACE_DIS_TO_CYC + 1);
	localparam int          LKON_PH_W   = $clog2(LKON_PERIOD_CYC);
	localparam logic [1:0]  STRAP_WAIT  = 2'h3;
	localparam logic [2:0]  PC_MAX_WAKE = 3'h4;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FLAG = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_PCLS = 8'h0c;

	// Control register fields
	localparam int         CTRL_LINK_CONTROL_BIT     = 0;
	localparam int         CTRL_CONTENDER = 1;
	localparam int         CTRL_RESUMING_PORT_IRQ_ENABLE      = 2;
	localparam logic [2:0] CTRL_RESET     = 3'h1;

	// Flag register fields
	localparam int FLG_PORT_EVENT = 0;
	localparam int FLG_CFG_TO     = 1;
	localparam int FLG_CPS        = 2;
	localparam int FLG_STATE_TO   = 3;

	// Positions in the synchroniser vector
	localparam int SI_LPS   = 0;
	localparam int SI_INTERFACE_PROTOCOL_SELECT = 1;
	localparam int SI_DS0   = 2;
	localparam int SI_DS1   = 3;
	localparam int SI_PC    = 4;
	localparam int SI_LKON  = 7;
	localparam int SI_CPS   = 8;
	localparam int SI_BIAS  = 9;
	localparam int SI_LINK_REQUEST  = 12;
	localparam int SYNC_W   = 13;

	typedef enum logic [1:0] {
		IF_DISABLED = 2'b00,
		IF_INIT     = 2'b01,
		IF_ACTIVE   = 2'b11,
		IF_RESET    = 2'b10
	} lpsm_iface_type;

endpackage

// *** lpsm_sync.sv ***
// Two-flop synchroniser bank for pins from outside the clock domain
`timescale 1ns/1ps
module lpsm_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				meta_ff[i]  <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta_ff[i]  <= async_in[i];
				sync_out[i] <= meta_ff[i];
			end
		end
	end
endmodule

// *** lpsm_top.sv ***
// Link power status manager: interface state, link-on, straps, AHB registers
// Operation
// RQ1 - Status input counts inactive only after low longer than reset timeout.
// RQ2 - Reset timeout about 2.6 us, disable timeout about 26 us of low.
// RQ3 - Inactive status: control and data lines held 0, requests ignored, clock runs.
// RQ4 - Low past disable timeout: disabled state, link clock also stopped.
// RQ5 - Cable repeating continues whatever the interface state.
// RQ6 - Status active again from reset or disabled: initialise interface, resume.
// RQ7 - Interface held disabled while hardware reset is applied.
// RQ8 - Return from disabled state issues a bus reset.
// RQ9 - Interface state depends on status input only, not link control bit.
// RQ10 - Link active only when status active and link control bit set.
// RQ11 - Link-on square wave while link inactive and a wake-up occurred.
// RQ12 - Link-on period eight clocks, else driven low, released during reset.
// RQ13 - Wake-up: link-on packet for this node, or qualifying interrupt.
// RQ14 - Port event flag wakes; other flags wake only with resume enable.
// RQ15 - Link-on stops once link becomes active.
// RQ16 - Bus reset stops link-on unless an interrupt wake-up persists; the code clears only the packet request, so power-up link-on runs on.
// RQ17 - After power-up with class 0 to 4, link-on runs about 167 us.
// RQ18 - Strobe-only straps sampled at reset; 1 forces data-strobe only.
// RQ19 - Strobe-only port never gets 1394b signalling.
// RQ20 - Power class straps give power class default.
// RQ21 - Contender bit set only by a register write.
// RQ22 - Protocol select high gives 1394b interface, low gives 1394a.
// RQ23 - Protocol select must not change during operation.
// RQ24 - Cable-not-active high when no port sees bias, low otherwise.
// RQ25 - Cable power loss raises an interrupt flag.
// RQ26 - Low time counted in clocks, restarted on any high sample.
`timescale 1ns/1ps
module lpsm_top #(
	parameter int PWRUP_CYCLES = lpsm_pkg::PWRUP_LKON_CYC
) (
	input  wire logic        REF_CLK_IN,
	input  wire logic        SYS_RST_IN,
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output logic      [31:0] HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT,
	input  wire logic        LINK_POWER_STATUS_IN,
	input  wire logic        INTERFACE_PROTOCOL_SELECT_IN,
	input  wire logic        PORT0_STROBE_ONLY_STRAP_IN,
	input  wire logic        PORT1_STROBE_ONLY_STRAP_IN,
	input  wire logic        POWER_CLASS_STRAP0_IN,
	input  wire logic        POWER_CLASS_STRAP1_IN,
	input  wire logic        POWER_CLASS_STRAP2_IN,
	input  wire logic        LINK_ON_OR_PORT2_STRAP_IN,
	output logic             LINK_ON_OR_PORT2_STRAP_OUT,
	output logic             LINK_ON_OR_PORT2_STRAP_OE_OUT,
	input  wire logic        CABLE_POWER_SENSE_IN,
	input  wire logic [2:0]  PORT_BIAS_DETECT_IN,
	input  wire logic        LINK_REQUEST_IN,
	input  wire logic [1:0]  CORE_CTL_IN,
	input  wire logic        CORE_CTL_OE_IN,
	input  wire logic [7:0]  CORE_DATA_IN,
	input  wire logic        CORE_DATA_OE_IN,
	input  wire logic        LINK_ON_PACKET_IN,
	input  wire logic        BUS_RESET_IN,
	input  wire logic        PORT_EVENT_IN,
	input  wire logic        CONFIG_TIMEOUT_IN,
	input  wire logic        STATE_TIMEOUT_IN,
	output logic             PHY_LINK_CONTROL_LINE0_OUT,
	output logic             PHY_LINK_CONTROL_LINE1_OUT,
	output logic             PHY_LINK_CONTROL_OE_OUT,
	output logic      [7:0]  PHY_LINK_DATA_LINES_OUT,
	output logic             PHY_LINK_DATA_OE_OUT,
	output logic             LINK_REQUEST_OUT,
	output logic             PHY_LINK_CLOCK_RUN_OUT,
	output logic             IFACE_INIT_OUT,
	output logic             BUS_RESET_REQ_OUT,
	output logic             LINK_ACTIVE_OUT,
	output logic             CONTENDER_OUT,
	output logic      [2:0]  POWER_CLASS_OUT,
	output logic      [2:0]  BETA_SIGNAL_EN_OUT,
	output logic             IFACE_PROTOCOL_B_OUT,
	output logic             CABLE_NOT_ACTIVE_OUT,
	output logic             REPEATER_EN_OUT
);
	import lpsm_pkg::*;

	typedef struct packed {
		lpsm_iface_type       iface;
		logic [9:0]           lps_cnt;
		logic [12:0]          pwr_tmr;
		logic [LKON_PH_W-1:0] lkon_ph;
		logic                 lkon_on;
		logic                 lkon_out;
		logic                 lkon_oe;
		logic                 lkon_req;
		logic [1:0]           strap_cnt;
		logic                 strap_done;
		logic [2:0]           ds_only;
		logic [2:0]           pcls;
		logic [2:0]           ctrl;
		logic [3:0]           flags;
		logic                 cps_prev;
		logic                 bus_rst;
		logic                 init_pls;
		logic [1:0]           ctl;
		logic                 ctl_oe;
		logic [7:0]           dat;
		logic                 dat_oe;
		logic                 link_request;
		logic                 pclk_run;
		logic                 link_act;
		logic                 cable_not_active;
		logic                 interface_protocol_select;
		logic [2:0]           beta_en;
		logic                 rep_en;
		logic                 ahb_wr;
		logic                 ahb_rd;
		logic [7:0]           ahb_addr;
		logic [31:0]          hrdata;
		logic                 hreadyout;
	} lpsm_state_type;
	lpsm_state_type    s_ff;
	lpsm_state_type    nxt_s;
	logic [SYNC_W-1:0] sy;
	logic              lps_inact;
	logic              lps_dis;
	logic              irq_wake;
	logic              cps_fall;
	logic [3:0]        flg_set;
	logic [3:0]        flg_clr;
	logic [31:0]       rd_mux;
	lpsm_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk_in  (REF_CLK_IN),
		.rst_in  (SYS_RST_IN),
		.async_in({LINK_REQUEST_IN, PORT_BIAS_DETECT_IN, CABLE_POWER_SENSE_IN,
			LINK_ON_OR_PORT2_STRAP_IN, POWER_CLASS_STRAP2_IN, POWER_CLASS_STRAP1_IN,
			POWER_CLASS_STRAP0_IN, PORT1_STROBE_ONLY_STRAP_IN,
			PORT0_STROBE_ONLY_STRAP_IN, INTERFACE_PROTOCOL_SELECT_IN,
			LINK_POWER_STATUS_IN}),
		.sync_out(sy)
	);

	always_comb begin
		nxt_s = s_ff;
		// Thresholds compare the registered count; it saturates so disabled is sticky
		lps_inact = s_ff.lps_cnt > IFR_CNT; // RQ1 RQ2
		lps_dis   = s_ff.lps_cnt > IFD_CNT; // RQ2
		if (sy[SI_LPS]) begin
			nxt_s.lps_cnt = 10'h000; // RQ26
		end else if (s_ff.lps_cnt != LPS_CNT_SAT) begin
			nxt_s.lps_cnt = s_ff.lps_cnt + 10'h001; // RQ26
		end
		// Interface state follows the status input alone
		nxt_s.bus_rst = 1'b0;
		case (s_ff.iface) // RQ9
			IF_DISABLED: begin
				if (!lps_inact) begin
					nxt_s.iface   = IF_INIT; // RQ6
					nxt_s.bus_rst = 1'b1; // RQ8
				end
			end
			IF_INIT: begin
				nxt_s.iface = lps_inact ? IF_RESET : IF_ACTIVE; // RQ6
			end
			IF_ACTIVE: begin
				if (lps_inact) begin
					nxt_s.iface = IF_RESET; // RQ3
				end
			end
			IF_RESET: begin
				if (lps_dis) begin
					nxt_s.iface = IF_DISABLED; // RQ4
				end else if (!lps_inact) begin
					nxt_s.iface = IF_INIT; // RQ6
				end
			end
			default: begin
				nxt_s.iface = IF_DISABLED;
			end
		endcase
		nxt_s.init_pls = nxt_s.iface == IF_INIT;
		// Outside the active state the lines are driven low, not released
		if (nxt_s.iface == IF_ACTIVE) begin
			nxt_s.ctl    = CORE_CTL_IN;
			nxt_s.ctl_oe = CORE_CTL_OE_IN;
			nxt_s.dat    = CORE_DATA_IN;
			nxt_s.dat_oe = CORE_DATA_OE_IN;
		end else begin
			nxt_s.ctl    = 2'h0; // RQ3
			nxt_s.ctl_oe = 1'b1;
			nxt_s.dat    = 8'h00; // RQ3
			nxt_s.dat_oe = 1'b1;
		end
		nxt_s.link_request     = (nxt_s.iface == IF_ACTIVE) && sy[SI_LINK_REQUEST]; // RQ3
		nxt_s.pclk_run = nxt_s.iface != IF_DISABLED; // RQ4 RQ7
		nxt_s.rep_en   = 1'b1; // RQ5
		nxt_s.link_act = !lps_inact && s_ff.ctrl[CTRL_LINK_CONTROL_BIT]; // RQ10
		// Interrupt flags: set wins over a write-one clear in the same cycle
		nxt_s.cps_prev = sy[SI_CPS];
		cps_fall       = s_ff.cps_prev && !sy[SI_CPS]; // RQ25
		flg_set        = 4'h0;
		flg_set[FLG_PORT_EVENT] = PORT_EVENT_IN;
		flg_set[FLG_CFG_TO]     = CONFIG_TIMEOUT_IN;
		flg_set[FLG_CPS]        = cps_fall; // RQ25
		flg_set[FLG_STATE_TO]   = STATE_TIMEOUT_IN;
		flg_clr = (s_ff.ahb_wr && s_ff.ahb_addr == OFS_FLAG) ? HWDATA_IN[3:0] : 4'h0;
		nxt_s.flags = (s_ff.flags & ~flg_clr) | flg_set;
		irq_wake = s_ff.flags[FLG_PORT_EVENT] || (s_ff.ctrl[CTRL_RESUMING_PORT_IRQ_ENABLE] &&
			(s_ff.flags[FLG_CFG_TO] || s_ff.flags[FLG_CPS] || s_ff.flags[FLG_STATE_TO])); // RQ14
		// Straps are read once the synchronisers hold post-reset pin levels
		if (!s_ff.strap_done) begin
			if (s_ff.strap_cnt == STRAP_WAIT) begin
				nxt_s.strap_done = 1'b1;
				nxt_s.ds_only    = {sy[SI_LKON], sy[SI_DS1], sy[SI_DS0]}; // RQ18
				nxt_s.pcls       = sy[SI_PC+:3]; // RQ20
				if (sy[SI_PC+:3] <= PC_MAX_WAKE) begin
					nxt_s.pwr_tmr = 13'(PWRUP_CYCLES); // RQ17
				end
			end else begin
				nxt_s.strap_cnt = s_ff.strap_cnt + 2'h1;
			end
		end else if (s_ff.link_act) begin
			nxt_s.pwr_tmr = 13'h0000; // RQ17
		end else if (s_ff.pwr_tmr != 13'h0000) begin
			nxt_s.pwr_tmr = s_ff.pwr_tmr - 13'h0001; // RQ17
		end
		nxt_s.beta_en = nxt_s.strap_done ? ~nxt_s.ds_only : 3'h0; // RQ19
		// Link-on: packet request is sticky, interrupt wake is a live level
		if (LINK_ON_PACKET_IN && !s_ff.link_act) begin
			nxt_s.lkon_req = 1'b1; // RQ13
		end else if (s_ff.link_act || BUS_RESET_IN) begin
			nxt_s.lkon_req = 1'b0; // RQ15 RQ16
		end
		nxt_s.lkon_on = s_ff.strap_done && !s_ff.link_act &&
			(s_ff.lkon_req || irq_wake || s_ff.pwr_tmr != 13'h0000); // RQ11 RQ13 RQ15
		nxt_s.lkon_ph  = s_ff.lkon_on ? s_ff.lkon_ph + 1'b1 : '0; // RQ12
		nxt_s.lkon_out = nxt_s.lkon_on && nxt_s.lkon_ph[LKON_PH_W-1]; // RQ12
		// Pin stays released until the port 2 strap has been captured
		nxt_s.lkon_oe  = s_ff.strap_done; // RQ12
		nxt_s.cable_not_active   = ~|sy[SI_BIAS+:3]; // RQ24
		nxt_s.interface_protocol_select = sy[SI_INTERFACE_PROTOCOL_SELECT]; // RQ22
		// Register file
		rd_mux = 32'h0000_0000;
		case (s_ff.ahb_addr)
			OFS_CTRL: rd_mux = {29'h0, s_ff.ctrl};
			OFS_FLAG: rd_mux = {28'h0, s_ff.flags};
			OFS_STAT: rd_mux = {22'h0, s_ff.strap_done, s_ff.ds_only, s_ff.interface_protocol_select,
				s_ff.cable_not_active, s_ff.lkon_on, s_ff.link_act, s_ff.iface};
			OFS_PCLS: rd_mux = {29'h0, s_ff.pcls};
			default:  rd_mux = 32'h0000_0000;
		endcase
		if (s_ff.ahb_wr) begin
			if (s_ff.ahb_addr == OFS_CTRL) begin
				nxt_s.ctrl = HWDATA_IN[2:0]; // RQ21
			end
			if (s_ff.ahb_addr == OFS_PCLS) begin
				nxt_s.pcls = HWDATA_IN[2:0];
			end
		end
		// Reads take one wait state so a write just before is always seen
		nxt_s.ahb_wr    = 1'b0;
		nxt_s.ahb_rd    = 1'b0;
		nxt_s.hreadyout = 1'b1;
		if (s_ff.ahb_rd) begin
			nxt_s.hrdata = rd_mux;
		end else if (HSEL_IN && HTRANS_IN[1] && HREADY_IN) begin
			nxt_s.ahb_addr  = {HADDR_IN[7:2], 2'b00};
			nxt_s.ahb_wr    = HWRITE_IN;
			nxt_s.ahb_rd    = !HWRITE_IN;
			nxt_s.hreadyout = HWRITE_IN;
		end
	end

	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			s_ff           <= '0;
			s_ff.iface     <= IF_DISABLED; // RQ7
			s_ff.lps_cnt   <= LPS_CNT_SAT; // RQ7
			s_ff.ctrl      <= CTRL_RESET;
			s_ff.ctl_oe    <= 1'b1;
			s_ff.dat_oe    <= 1'b1;
			s_ff.rep_en    <= 1'b1;
			s_ff.cable_not_active       <= 1'b1;
			s_ff.hreadyout <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign HRDATA_OUT                    = s_ff.hrdata;
	assign HREADYOUT_OUT                 = s_ff.hreadyout;
	assign HRESP_OUT                     = 1'b0;
	assign LINK_ON_OR_PORT2_STRAP_OUT    = s_ff.lkon_out;
	assign LINK_ON_OR_PORT2_STRAP_OE_OUT = s_ff.lkon_oe;
	assign PHY_LINK_CONTROL_LINE0_OUT    = s_ff.ctl[0];
	assign PHY_LINK_CONTROL_LINE1_OUT    = s_ff.ctl[1];
	assign PHY_LINK_CONTROL_OE_OUT       = s_ff.ctl_oe;
	assign PHY_LINK_DATA_LINES_OUT       = s_ff.dat;
	assign PHY_LINK_DATA_OE_OUT          = s_ff.dat_oe;
	assign LINK_REQUEST_OUT              = s_ff.link_request;
	assign PHY_LINK_CLOCK_RUN_OUT        = s_ff.pclk_run;
	assign IFACE_INIT_OUT                = s_ff.init_pls;
	assign BUS_RESET_REQ_OUT             = s_ff.bus_rst;
	assign LINK_ACTIVE_OUT               = s_ff.link_act;
	assign CONTENDER_OUT                 = s_ff.ctrl[CTRL_CONTENDER];
	assign POWER_CLASS_OUT               = s_ff.pcls;
	assign BETA_SIGNAL_EN_OUT            = s_ff.beta_en;
	assign IFACE_PROTOCOL_B_OUT          = s_ff.interface_protocol_select;
	assign CABLE_NOT_ACTIVE_OUT          = s_ff.cable_not_active;
	assign REPEATER_EN_OUT               = s_ff.rep_en;

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	chk_iface_reset_entry: assert property ( // RQ1
		(s_ff.iface == IF_ACTIVE && s_ff.lps_cnt == IFR_CNT && !sy[SI_LPS])
		|-> ##1 s_ff.iface == IF_ACTIVE ##1 s_ff.iface == IF_RESET)
		else $error("interface did not enter reset after low timeout");
	chk_reset_lines_low: assert property ( // RQ3
		(s_ff.iface != IF_ACTIVE) |-> (s_ff.ctl == 2'h0 && s_ff.dat == 8'h00
		&& s_ff.ctl_oe && s_ff.dat_oe && !s_ff.link_request))
		else $error("lines not held low outside active state");
	chk_disable_clock: assert property ( // RQ4
		(s_ff.iface == IF_RESET && lps_dis) |=> (s_ff.iface == IF_DISABLED && !s_ff.pclk_run))
		else $error("link clock not stopped in disabled state");
	chk_reset_keeps_clock: assert property ( // RQ3
		(s_ff.iface == IF_RESET) |-> s_ff.pclk_run)
		else $error("link clock stopped in reset state");
	// Keyed on the cleared count so the wake is claimed once, not on every high sample
	chk_wake_bus_reset: assert property ( // RQ8
		(s_ff.iface == IF_DISABLED && !lps_inact) |=> (s_ff.bus_rst && s_ff.init_pls)
		##1 (!s_ff.bus_rst && s_ff.iface == IF_ACTIVE))
		else $error("no bus reset on return from disabled");
	chk_link_active: assert property ( // RQ10
		(!lps_inact && s_ff.ctrl[CTRL_LINK_CONTROL_BIT]) |=> s_ff.link_act)
		else $error("link not reported active");
	chk_link_inactive: assert property ( // RQ10
		(lps_inact || !s_ff.ctrl[CTRL_LINK_CONTROL_BIT]) |=> !s_ff.link_act)
		else $error("link reported active wrongly");
	chk_lkon_square: assert property ( // RQ12
		($rose(s_ff.lkon_out) ##1 s_ff.lkon_on [*3]) |-> ##1 !s_ff.lkon_out)
		else $error("link-on high phase not four cycles");
	chk_lkon_stop: assert property ( // RQ15
		s_ff.link_act |=> (!s_ff.lkon_on ##1 !s_ff.lkon_out))
		else $error("link-on still active with link active");
	chk_irq_wake: assert property ( // RQ14
		(s_ff.flags[FLG_PORT_EVENT] && s_ff.strap_done && !s_ff.link_act) |=> s_ff.lkon_on)
		else $error("port event did not wake the link");
	chk_flag_set_wins: assert property ( // RQ25
		cps_fall |=> s_ff.flags[FLG_CPS])
		else $error("cable power flag lost");
	chk_strobe_only: assert property ( // RQ19
		(s_ff.strap_done && s_ff.ds_only != 3'h0) |-> ((s_ff.beta_en & s_ff.ds_only) == 3'h0))
		else $error("strobe-only port given beta signalling");
	chk_cable_idle: assert property ( // RQ24
		(sy[SI_BIAS+:3] == 3'h0) |=> s_ff.cable_not_active)
		else $error("cable-not-active low with no bias");
	chk_lkon_released: assert property ( // RQ12
		!s_ff.strap_done |=> !s_ff.lkon_oe)
		else $error("link-on driven before strap sampling");
	cov_reset_state: cover property (s_ff.iface == IF_ACTIVE ##1 s_ff.iface == IF_RESET);
	cov_bus_reset: cover property (s_ff.bus_rst);
	cov_lkon_wave: cover property ($rose(s_ff.lkon_out));
	cov_reg_read: cover property (s_ff.ahb_rd ##1 s_ff.hreadyout);
endmodule

// *** lpsm_link_model.sv ***
// Link-layer controller model: power status pin, request pin, wake on link-on
`timescale 1ns/1ps
module lpsm_link_model (
	input  wire logic       clk_in,
	input  wire logic [1:0] mode_in,
	input  wire logic       lkon_in,
	output logic            lps_out,
	output logic            link_request_out
);
	logic pulse = 1'b0;
	logic woke = 1'b0;
	logic lkon_prev = 1'b1;
	logic link_request = 1'b0;
	// Pulsed status at 320 ns, edges a fixed 13 ns before a rising clock edge
	initial begin
		#7;
		forever #160 pulse = ~pulse;
	end
	// Mode 3 sleeps until a rising link-on edge; reset-time strap level alone never wakes it
	always @(posedge clk_in) begin
		woke <= (mode_in == 2'h3) & (woke | (lkon_in & ~lkon_prev));
		lkon_prev <= lkon_in;
		link_request <= ~link_request;
	end
	assign link_request_out = link_request;
	// Modes: 0 off, 1 steady, 2 pulsed with short lows, 3 asleep
	assign lps_out = (mode_in == 2'h1) | ((mode_in == 2'h2) & pulse) | woke;
endmodule

// *** tb.sv ***
// Self-checking testbench for the link power status manager
`timescale 1ns/1ps
module tb;
	import lpsm_pkg::*;
	logic REF_CLK_IN, SYS_RST_IN, HSEL_IN, HWRITE_IN, HREADY_IN, HRESP_OUT, HREADYOUT_OUT;
	logic [31:0] HADDR_IN, HWDATA_IN, HRDATA_OUT;
	logic [1:0]  HTRANS_IN, CORE_CTL_IN, mode;
	logic [2:0]  HSIZE_IN, PORT_BIAS_DETECT_IN, POWER_CLASS_OUT, BETA_SIGNAL_EN_OUT, pc;
	logic [7:0]  CORE_DATA_IN, PHY_LINK_DATA_LINES_OUT;
	logic LINK_POWER_STATUS_IN, INTERFACE_PROTOCOL_SELECT_IN, PORT0_STROBE_ONLY_STRAP_IN;
	logic PORT1_STROBE_ONLY_STRAP_IN, LINK_ON_OR_PORT2_STRAP_IN, LINK_ON_OR_PORT2_STRAP_OUT;
	logic LINK_ON_OR_PORT2_STRAP_OE_OUT, CABLE_POWER_SENSE_IN, LINK_REQUEST_IN, CORE_CTL_OE_IN;
	logic CORE_DATA_OE_IN, LINK_ON_PACKET_IN, BUS_RESET_IN, PORT_EVENT_IN, CONFIG_TIMEOUT_IN;
	logic STATE_TIMEOUT_IN, PHY_LINK_CONTROL_LINE0_OUT, PHY_LINK_CONTROL_LINE1_OUT;
	logic PHY_LINK_CONTROL_OE_OUT, PHY_LINK_DATA_OE_OUT, LINK_REQUEST_OUT, PHY_LINK_CLOCK_RUN_OUT;
	logic IFACE_INIT_OUT, BUS_RESET_REQ_OUT, LINK_ACTIVE_OUT, CONTENDER_OUT, IFACE_PROTOCOL_B_OUT;
	logic CABLE_NOT_ACTIVE_OUT, REPEATER_EN_OUT, strap2;
	logic POWER_CLASS_STRAP0_IN, POWER_CLASS_STRAP1_IN, POWER_CLASS_STRAP2_IN;
	int error_cnt = 0;
	int check_count = 0;
	wire [11:0] lines = {PHY_LINK_CONTROL_LINE1_OUT, PHY_LINK_CONTROL_LINE0_OUT,
		PHY_LINK_DATA_LINES_OUT, PHY_LINK_CONTROL_OE_OUT, PHY_LINK_DATA_OE_OUT};
	assign HREADY_IN = HREADYOUT_OUT;
	// Strap resistor shows on the pin only while the block releases it
	assign LINK_ON_OR_PORT2_STRAP_IN = LINK_ON_OR_PORT2_STRAP_OE_OUT ?
		LINK_ON_OR_PORT2_STRAP_OUT : strap2;
	assign {POWER_CLASS_STRAP2_IN, POWER_CLASS_STRAP1_IN, POWER_CLASS_STRAP0_IN} = pc;
	lpsm_top #(.PWRUP_CYCLES(20)) u_lpsm_top (.*);
	lpsm_link_model u_lpsm_link_model (.clk_in(REF_CLK_IN), .mode_in(mode),
		.lkon_in(LINK_ON_OR_PORT2_STRAP_IN), .lps_out(LINK_POWER_STATUS_IN),
		.link_request_out(LINK_REQUEST_IN));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge REF_CLK_IN);
	endtask
	// Single-word transfer; only the watchdog bounds the waits on ready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge REF_CLK_IN);
		HSEL_IN <= 1'b1;
		HTRANS_IN <= 2'h2;
		HADDR_IN <= {24'h0, a};
		HWRITE_IN <= w;
		do begin
			@(posedge REF_CLK_IN);
		end while (HREADY_IN !== 1'b1);
		HSEL_IN <= 1'b0;
		HTRANS_IN <= 2'h0;
		HWDATA_IN <= d;
		do begin
			@(posedge REF_CLK_IN);
		end while (HREADY_IN !== 1'b1);
		r = HRDATA_OUT;
	endtask
	task automatic stat(input logic [1:0] e);
		logic [31:0] r;
		bus(1'b0, OFS_STAT, 32'h0, r);
		chk("iface state", r[1:0], e);
	endtask
	task automatic lk(input int e);
		logic p;
		int r;
		r = 0;
		p = LINK_ON_OR_PORT2_STRAP_OUT;
		repeat (64) begin
			@(posedge REF_CLK_IN);
			if (LINK_ON_OR_PORT2_STRAP_OUT === 1'b1 && p === 1'b0) r++;
			p = LINK_ON_OR_PORT2_STRAP_OUT;
		end
		chk("link-on rises in 64 cycles", r, e);
	endtask
	// Bit 0 records a bus reset pulse, bit 1 an interface initialisation pulse
	task automatic wait_brst(input int n, output logic [1:0] hit);
		hit = 2'b00;
		repeat (n) begin
			@(posedge REF_CLK_IN);
			if (BUS_RESET_REQ_OUT === 1'b1) hit[0] = 1'b1;
			if (IFACE_INIT_OUT === 1'b1) hit[1] = 1'b1;
		end
	endtask
	// One-cycle core event: 0 packet, 1 bus reset, 2 port event, 3 config, 4 state
	task automatic ev(input int k);
		{LINK_ON_PACKET_IN, BUS_RESET_IN, PORT_EVENT_IN, CONFIG_TIMEOUT_IN,
			STATE_TIMEOUT_IN} <= 5'h10 >> k;
		@(posedge REF_CLK_IN);
		{LINK_ON_PACKET_IN, BUS_RESET_IN, PORT_EVENT_IN, CONFIG_TIMEOUT_IN,
			STATE_TIMEOUT_IN} <= 5'h0;
		cyc(4);
	endtask
	task automatic t_power_up;
		logic [1:0] hit;
		logic [31:0] r;
		wait_brst(300, hit);
		chk("bus reset after power-up wake", hit, 2'b11);
		mode <= 2'h1;
		cyc(4);
		chk("clock run", PHY_LINK_CLOCK_RUN_OUT, 1);
		bus(1'b0, OFS_STAT, 32'h0, r);
		chk("status word", r, 32'h377);
		chk("signalling enable", BETA_SIGNAL_EN_OUT, 3'b010);
		chk("protocol", IFACE_PROTOCOL_B_OUT, 1);
		lk(0);
		{PORT1_STROBE_ONLY_STRAP_IN, PORT0_STROBE_ONLY_STRAP_IN, strap2} <= 3'b100;
		pc <= 3'h7;
		cyc(4);
		chk("straps held", BETA_SIGNAL_EN_OUT, 3'b010);
		chk("power class", POWER_CLASS_OUT, 3'h2);
	endtask
	task automatic t_registers;
		logic [31:0] r;
		bus(1'b0, OFS_CTRL, 32'h0, r);
		chk("ctrl reset", r, 32'h1);
		bus(1'b1, OFS_CTRL, 32'h3, r);
		cyc(1);
		chk("contender", CONTENDER_OUT, 1);
		bus(1'b0, 8'h10, 32'h0, r);
		chk("unmapped read", r, 32'h0);
		chk("okay response", HRESP_OUT, 0);
		bus(1'b1, OFS_PCLS, 32'h6, r);
		bus(1'b0, OFS_PCLS, 32'h0, r);
		chk("power class write", r, 32'h6);
		bus(1'b1, OFS_CTRL, 32'h1, r);
		cyc(1);
		chk("contender clear", CONTENDER_OUT, 0);
	endtask
	task automatic t_lps;
		logic [1:0] hit;
		logic q;
		mode <= 2'h0;
		cyc(50);
		mode <= 2'h2;
		cyc(300);
		stat(2'h3);
		mode <= 2'h0;
		cyc(100);
		stat(2'h2);
		chk("lines held low", lines, 12'h003);
		chk("request ignored", LINK_REQUEST_OUT, 0);
		chk("clock run", PHY_LINK_CLOCK_RUN_OUT, 1);
		chk("link inactive", LINK_ACTIVE_OUT, 0);
		chk("repeater", REPEATER_EN_OUT, 1);
		CORE_CTL_IN <= 2'h1;
		CORE_DATA_IN <= 8'h5a;
		mode <= 2'h1;
		wait_brst(10, hit);
		chk("no bus reset from reset state", hit, 2'b10);
		stat(2'h3);
		chk("lines pass", lines, 12'h56b);
		q = LINK_REQUEST_OUT;
		cyc(1);
		chk("request passes", LINK_REQUEST_OUT, !q);
		mode <= 2'h0;
		cyc(720);
		chk("clock stopped", PHY_LINK_CLOCK_RUN_OUT, 0);
		stat(2'h0);
		mode <= 2'h1;
		wait_brst(10, hit);
		chk("bus reset after disable", hit, 2'b11);
		chk("clock run", PHY_LINK_CLOCK_RUN_OUT, 1);
	endtask
	task automatic t_wake;
		logic [31:0] r;
		bus(1'b1, OFS_CTRL, 32'h0, r);
		cyc(2);
		chk("link inactive", LINK_ACTIVE_OUT, 0);
		stat(2'h3);
		lk(0);
		ev(0);
		lk(8);
		ev(1);
		lk(0);
		ev(3);
		lk(0);
		bus(1'b1, OFS_CTRL, 32'h4, r);
		cyc(4);
		lk(8);
		ev(1);
		lk(8);
		bus(1'b1, OFS_FLAG, 32'h2, r);
		cyc(4);
		lk(0);
		ev(4);
		lk(8);
		bus(1'b1, OFS_FLAG, 32'h8, r);
		ev(2);
		lk(8);
		bus(1'b1, OFS_CTRL, 32'h5, r);
		cyc(4);
		lk(0);
		chk("link-on low", {LINK_ON_OR_PORT2_STRAP_OE_OUT, LINK_ON_OR_PORT2_STRAP_OUT}, 2'b10);
		bus(1'b1, OFS_FLAG, 32'h1, r);
		bus(1'b0, OFS_FLAG, 32'h0, r);
		chk("flags cleared", r, 32'h0);
	endtask
	task automatic t_cable;
		logic [31:0] r;
		PORT_BIAS_DETECT_IN <= 3'h4;
		cyc(4);
		chk("cable not active", CABLE_NOT_ACTIVE_OUT, 0);
		PORT_BIAS_DETECT_IN <= 3'h0;
		cyc(4);
		chk("cable not active", CABLE_NOT_ACTIVE_OUT, 1);
		CABLE_POWER_SENSE_IN <= 1'b0;
		cyc(5);
		bus(1'b0, OFS_FLAG, 32'h0, r);
		chk("cable power flag", r, 32'h4);
	endtask
	initial begin
		REF_CLK_IN = 1'b0;
		forever #20 REF_CLK_IN = ~REF_CLK_IN;
	end
	initial begin
		cyc(6000);
		error_cnt++;
		complete_run();
	end
	initial begin
		SYS_RST_IN = 1'b1;
		{HSEL_IN, HWRITE_IN, HADDR_IN, HWDATA_IN, HTRANS_IN} = '0;
		HSIZE_IN = 3'h2;
		INTERFACE_PROTOCOL_SELECT_IN = 1'b1;
		{PORT1_STROBE_ONLY_STRAP_IN, PORT0_STROBE_ONLY_STRAP_IN, strap2} = 3'b011;
		pc = 3'h2;
		CABLE_POWER_SENSE_IN = 1'b1;
		PORT_BIAS_DETECT_IN = 3'h0;
		{CORE_CTL_IN, CORE_CTL_OE_IN, CORE_DATA_IN, CORE_DATA_OE_IN} = {2'h3, 1'b1, 8'ha5, 1'b1};
		{LINK_ON_PACKET_IN, BUS_RESET_IN, PORT_EVENT_IN, CONFIG_TIMEOUT_IN, STATE_TIMEOUT_IN} = '0;
		mode = 2'h3;
		cyc(5);
		chk("link-on released in reset", LINK_ON_OR_PORT2_STRAP_OE_OUT, 0);
		chk("clock run in reset", PHY_LINK_CLOCK_RUN_OUT, 0);
		cyc(1);
		SYS_RST_IN <= 1'b0;
		t_power_up();
		t_registers();
		t_lps();
		t_wake();
		t_cable();
		complete_run();
	end
endmodule
